// File: inc/tlc_pkg.sv
// Constants and carrier types of the tag link coding block
package tlc_pkg;
  // ----------------------------------------------------------
  // Configuration word
  // ----------------------------------------------------------
  localparam int         CFG_KEY_LSB = 0;
  localparam int         CFG_XMODE   = 15;
  localparam int         CFG_MARKER  = 29;
  localparam int         CFG_FAST    = 30;
  localparam int         CFG_INVERSE = 31;
  localparam logic [3:0] KEY_EXT_A   = 4'h6;
  localparam logic [3:0] KEY_EXT_B   = 4'h9;
  localparam logic [1:0] MARKER_RST  = 2'h1;
  localparam int         FIFO_DEPTH  = 32;
  // ----------------------------------------------------------
  // Gap interval windows, in field clocks
  // ----------------------------------------------------------
  localparam logic [6:0] NRM_ZERO_MIN = 7'h10;
  localparam logic [6:0] NRM_ZERO_MAX = 7'h1F;
  localparam logic [6:0] NRM_ONE_MIN  = 7'h30;
  localparam logic [6:0] NRM_ONE_MAX  = 7'h3F;
  localparam logic [6:0] FST_ZERO_MIN = 7'h08;
  localparam logic [6:0] FST_ZERO_MAX = 7'h0F;
  localparam logic [6:0] FST_ONE_MIN  = 7'h18;
  localparam logic [6:0] FST_ONE_MAX  = 7'h1F;
  localparam logic [6:0] FST_TIMEOUT  = 7'h20;
  localparam logic [6:0] NRM_TIMEOUT  = 7'h40;
  localparam logic [6:0] CNT_START    = 7'h01;
  // ----------------------------------------------------------
  // Types
  // ----------------------------------------------------------
  // ctl=0: data bit in val; ctl=1: val=0 write end, val=1 abort
  typedef struct packed {
    logic ctl;
    logic val;
  } tlc_wr_t;
  localparam int WR_W = $bits(tlc_wr_t);

  typedef enum logic [2:0] {
    R_IDLE = 3'h1,
    R_OPEN = 3'h2,
    R_RUN  = 3'h4
  } tlc_rx_st_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'h1,
    T_MARK = 3'h2,
    T_DATA = 3'h4
  } tlc_tx_st_t;
endpackage

// File: core/tlc_coder.sv
// Tag link coding: write gap decoder, start marker, inverse output
`timescale 1ns/1ns

// ------------------------------------------------------------
// Flop FIFO
// ------------------------------------------------------------
module tlc_fifo #(
  parameter int W = 2,
  parameter int D = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_ce,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       rp;
    logic [AW-1:0]       wp;
    logic [AW:0]         cnt;
  } tlc_fifo_st_t;
  tlc_fifo_st_t s_r;
  tlc_fifo_st_t s_nxt;
  logic         push;
  logic         pop;

  assign o_ready = (s_r.cnt != FULL);
  assign o_valid = (s_r.cnt != '0);
  assign o_data  = s_r.mem[s_r.rp];
  assign push    = i_valid & o_ready & i_ce;
  assign pop     = o_valid & i_ready & i_ce;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = i_data;
      s_nxt.wp          = AW'(s_r.wp + 1'b1);
    end
    if (pop) begin
      s_nxt.rp = AW'(s_r.rp + 1'b1);
    end
    s_nxt.cnt = (AW+1)'(s_r.cnt + push - pop);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ------------------------------------------------------------
// Top
// ------------------------------------------------------------
module tlc_coder import tlc_pkg::*; #(
  parameter int HALF_CYC = 8
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_fclk,
  input  wire logic        i_gap,
  input  wire logic [31:0] i_cfg,
  input  wire logic        i_manch,
  input  wire logic        i_seq_start,
  input  wire logic        i_tx_valid,
  input  wire logic        i_tx_bit,
  output logic             o_tx_ready,
  output logic             o_mod_bit,
  output logic             o_damp,
  output logic             o_ext_mode,
  output logic             o_wr_active,
  output logic             o_wr_valid,
  input  wire logic        i_wr_ready,
  output tlc_wr_t          o_wr_data,
  output logic             o_rx_overflow,
  input  wire logic        i_ovf_clr
);
  localparam logic [7:0] T_LAST = 8'(2 * HALF_CYC - 1);
  localparam logic [7:0] T_HALF = 8'(HALF_CYC);

  typedef struct packed {
    logic       gap_s1;
    logic       gap_s2;
    logic       gap_d;
    logic       fst_s1;
    logic       fst_s2;
    logic       ce_s1;
    logic       ce_s2;
    tlc_rx_st_t st;
    logic [6:0] cnt;
    tlc_wr_t    ev;
    logic       tg;
  } tlc_link_st_t;

  typedef struct packed {
    logic       tg_s1;
    logic       tg_s2;
    logic       tg_d;
    logic       act_s1;
    logic       act_s2;
    logic       pend;
    tlc_wr_t    pev;
    logic       ovf;
    tlc_tx_st_t st;
    logic [1:0] mk;
    logic       mi;
    logic       dat;
    logic [7:0] tmr;
    logic       damp;
  } tlc_core_st_t;

  localparam tlc_link_st_t L_RST = '{st: R_IDLE, default: '0};
  localparam tlc_core_st_t C_RST = '{st: T_IDLE, mk: MARKER_RST, default: '0};

  tlc_link_st_t l_r;
  tlc_link_st_t l_nxt;
  tlc_core_st_t c_r;
  tlc_core_st_t c_nxt;
  logic         gs;
  logic         ge;
  logic         ext_en;
  logic         mk_en;
  logic         inv_en;
  logic         f_rdy;
  logic [3:0]   key;

  // ----------------------------------------------------------
  // Option decode
  // ----------------------------------------------------------
  assign key    = i_cfg[CFG_KEY_LSB +: 4];
  assign ext_en = i_cfg[CFG_XMODE] & ((key == KEY_EXT_A) | (key == KEY_EXT_B));
  assign mk_en  = ext_en & i_cfg[CFG_MARKER];
  assign inv_en = ext_en & i_cfg[CFG_INVERSE];
  assign o_ext_mode = ext_en;

  // Returns {valid, value} of one gap-to-gap interval
  function automatic logic [1:0] tlc_decode(input logic fst, input logic [6:0] n);
    logic z;
    logic o;
    z = fst ? (n >= FST_ZERO_MIN && n <= FST_ZERO_MAX)
            : (n >= NRM_ZERO_MIN && n <= NRM_ZERO_MAX);
    o = fst ? (n >= FST_ONE_MIN && n <= FST_ONE_MAX)
            : (n >= NRM_ONE_MIN && n <= NRM_ONE_MAX);
    return {z | o, o};
  endfunction

  // ----------------------------------------------------------
  // Field clock side: gap interval decoder
  // ----------------------------------------------------------
  // Counting from gap start to gap start keeps gap width out of the figure
  assign gs = l_r.gap_s2 & ~l_r.gap_d;
  assign ge = ~l_r.gap_s2 & l_r.gap_d;

  always_comb begin
    logic [1:0] dec;
    logic [6:0] tmo;
    dec   = tlc_decode(l_r.fst_s2, l_r.cnt);
    tmo   = l_r.fst_s2 ? FST_TIMEOUT : NRM_TIMEOUT;
    l_nxt = l_r;
    l_nxt.ce_s1 = i_ce;
    l_nxt.ce_s2 = l_r.ce_s1;
    if (l_r.ce_s2) begin
      l_nxt.gap_s1 = i_gap;
      l_nxt.gap_s2 = l_r.gap_s1;
      l_nxt.gap_d  = l_r.gap_s2;
      l_nxt.fst_s1 = i_cfg[CFG_FAST];
      l_nxt.fst_s2 = l_r.fst_s1;
      unique case (l_r.st)
        R_IDLE: begin
          if (gs) begin
            l_nxt.st = R_OPEN;
          end
        end
        R_OPEN: begin
          if (ge) begin
            l_nxt.st  = R_RUN;
            l_nxt.cnt = CNT_START;
          end
        end
        R_RUN: begin
          if (gs) begin
            l_nxt.tg  = ~l_r.tg;
            l_nxt.cnt = CNT_START;
            if (dec[1]) begin
              l_nxt.ev = '{ctl: 1'b0, val: dec[0]};
            end else begin
              l_nxt.ev = '{ctl: 1'b1, val: 1'b1};
              l_nxt.st = R_IDLE;
            end
          end else if (l_r.cnt > tmo) begin
            l_nxt.ev = '{ctl: 1'b1, val: 1'b0};
            l_nxt.tg = ~l_r.tg;
            l_nxt.st = R_IDLE;
          end else if (l_r.cnt != 7'h7F) begin
            l_nxt.cnt = 7'(l_r.cnt + 1'b1);
          end
        end
        default: begin
          l_nxt.st = R_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_fclk or negedge i_nrst) begin
    if (!i_nrst) begin
      l_r <= L_RST;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ----------------------------------------------------------
  // System side: event crossing, transmit encoder
  // ----------------------------------------------------------
  // Event word is stable for many field clocks once the toggle moves
  assign o_tx_ready = (c_r.st == T_DATA) && (c_r.tmr == '0) && i_ce;
  assign o_mod_bit  = c_r.dat;
  assign o_damp     = c_r.damp;
  assign o_wr_active   = c_r.act_s2;
  assign o_rx_overflow = c_r.ovf;

  always_comb begin
    logic ev_new;
    logic drop;
    c_nxt  = c_r;
    ev_new = c_r.tg_s2 ^ c_r.tg_d;
    drop   = 1'b0;
    if (i_ce) begin
      c_nxt.tg_s1  = l_r.tg;
      c_nxt.tg_s2  = c_r.tg_s1;
      c_nxt.tg_d   = c_r.tg_s2;
      c_nxt.act_s1 = (l_r.st != R_IDLE);
      c_nxt.act_s2 = c_r.act_s1;
      if (c_r.pend && f_rdy) begin
        c_nxt.pend = 1'b0;
      end
      if (ev_new) begin
        if (c_nxt.pend) begin
          drop = 1'b1;
        end else begin
          c_nxt.pend = 1'b1;
          c_nxt.pev  = l_r.ev;
        end
      end
      c_nxt.ovf = (c_r.ovf & ~i_ovf_clr) | drop;
      if (c_r.tmr != '0) begin
        c_nxt.tmr = 8'(c_r.tmr - 1'b1);
      end
      unique case (c_r.st)
        T_IDLE: begin
          if (i_seq_start && mk_en) begin
            c_nxt.st  = T_MARK;
            c_nxt.mk  = ~c_r.mk;
            c_nxt.dat = c_r.mk[1];
            c_nxt.mi  = 1'b0;
            c_nxt.tmr = T_LAST;
          end else if (i_seq_start) begin
            c_nxt.st  = T_DATA;
            c_nxt.tmr = '0;
          end
        end
        T_MARK: begin
          if (c_r.tmr == '0 && !c_r.mi) begin
            c_nxt.mi  = 1'b1;
            c_nxt.dat = ~c_r.mk[0];
            c_nxt.tmr = T_LAST;
          end else if (c_r.tmr == '0) begin
            c_nxt.st = T_DATA;
          end
        end
        T_DATA: begin
          if (c_r.tmr == '0 && i_tx_valid) begin
            c_nxt.dat = i_tx_bit ^ inv_en;
            c_nxt.tmr = T_LAST;
          end else if (c_r.tmr == '0) begin
            c_nxt.st = T_IDLE;
          end
        end
        default: begin
          c_nxt.st = T_IDLE;
        end
      endcase
      if (c_nxt.st == T_IDLE) begin
        c_nxt.damp = 1'b0;
      end else if (i_manch && c_nxt.tmr >= T_HALF) begin
        c_nxt.damp = ~c_nxt.dat;
      end else begin
        c_nxt.damp = c_nxt.dat;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      c_r <= C_RST;
    end else begin
      c_r <= c_nxt;
    end
  end

  // Sinks only; the reader cannot be stalled, so an event arriving while a full FIFO holds the pending slot sets overflow
  tlc_fifo #(
    .W (WR_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_ce    (i_ce),
    .i_valid (c_r.pend),
    .o_ready (f_rdy),
    .i_data  (c_r.pev),
    .o_valid (o_wr_valid),
    .i_ready (i_wr_ready),
    .o_data  (o_wr_data)
  );

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  a_marker_start: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && c_r.st == T_IDLE && i_seq_start && mk_en)
    |=> (c_r.st == T_MARK && c_r.dat == ~c_r.mk[1]))
    else $error("marker header did not start");
  a_marker_toggle: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && c_r.st == T_IDLE && i_seq_start && mk_en) |=> (c_r.mk == ~$past(c_r.mk)))
    else $error("marker value not inverted");
  a_inverse_data: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_tx_ready && i_tx_valid) |=> (c_r.dat == $past(i_tx_bit ^ inv_en)))
    else $error("modulator bit has wrong polarity");
  a_nrz_polarity: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (c_r.st == T_DATA && !i_manch && $stable(i_manch) && $past(c_r.st) == T_DATA)
    |-> (o_damp == c_r.dat))
    else $error("nrz damping level wrong");
  a_manch_mid: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_manch && c_r.st == T_DATA && c_r.tmr == T_HALF)
    |=> (o_damp == c_r.dat && $past(o_damp) == ~c_r.dat))
    else $error("manchester mid-bit edge wrong");
  a_write_timeout: assert property (@(posedge i_fclk) disable iff (!i_nrst)
    (l_r.ce_s2 && l_r.st == R_RUN && !gs
     && l_r.cnt > (l_r.fst_s2 ? FST_TIMEOUT : NRM_TIMEOUT))
    |=> (l_r.st == R_IDLE && l_r.ev == tlc_wr_t'(2'h2)))
    else $error("write mode not left after timeout");
  a_fast_zero: assert property (@(posedge i_fclk) disable iff (!i_nrst)
    (l_r.ce_s2 && l_r.st == R_RUN && gs && l_r.fst_s2 && l_r.cnt >= 7'h08
     && l_r.cnt <= 7'h0F) |=> (l_r.tg != $past(l_r.tg) && l_r.ev == tlc_wr_t'(2'h0)))
    else $error("fast zero not decoded");
  a_normal_one: assert property (@(posedge i_fclk) disable iff (!i_nrst)
    (l_r.ce_s2 && l_r.st == R_RUN && gs && !l_r.fst_s2 && l_r.cnt >= 7'h30
     && l_r.cnt <= 7'h3F) |=> (l_r.st == R_RUN && l_r.ev == tlc_wr_t'(2'h1)))
    else $error("normal one not decoded");
  a_bad_interval: assert property (@(posedge i_fclk) disable iff (!i_nrst)
    (l_r.ce_s2 && l_r.st == R_RUN && gs && !l_r.fst_s2 && l_r.cnt >= 7'h20
     && l_r.cnt <= 7'h2F) |=> (l_r.st == R_IDLE && l_r.ev == tlc_wr_t'(2'h3)))
    else $error("invalid interval not aborted");
endmodule

// File: sim/tlc_reader.sv
// Reader model: free running field clock and write gaps
`timescale 1ns/1ns
module tlc_reader (
  output logic o_fclk,
  output logic o_gap
);
  initial o_fclk = 1'b0;
  initial o_gap = 1'b0;
  // Recovered from the carrier, so it runs through gaps as well
  always #24 o_fclk = ~o_fclk;

  // Opening gap, then gaps spaced iv[k] field clocks, iv[0] from the end of the opening gap, the rest start to start
  task automatic send(input int iv[$]);
    @(negedge o_fclk);
    o_gap = 1'b1;
    repeat (20) @(negedge o_fclk);
    o_gap = 1'b0;
    foreach (iv[k]) begin
      repeat (k ? iv[k] - 8 : iv[k]) @(negedge o_fclk);
      o_gap = 1'b1;
      repeat (8) @(negedge o_fclk);
      o_gap = 1'b0;
    end
  endtask
endmodule

// File: sim/tb.sv
// Self-checking bench of the tag link coder
`timescale 1ns/1ns
module tb;
  import tlc_pkg::*;
  localparam int H = 2;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_ce = 1'b1;
  logic        i_fclk;
  logic        i_gap;
  logic [31:0] i_cfg = 32'h0;
  logic        i_manch = 1'b0;
  logic        i_seq_start = 1'b0;
  logic        i_tx_valid = 1'b0;
  logic        i_tx_bit = 1'b0;
  logic        i_wr_ready = 1'b1;
  logic        i_ovf_clr = 1'b0;
  logic        o_tx_ready, o_mod_bit, o_damp, o_ext_mode;
  logic        o_wr_active, o_wr_valid, o_rx_overflow;
  tlc_wr_t     o_wr_data;
  int          err_count = 0;
  int          check_count = 0;
  tlc_wr_t     exq[$];
  logic [1:0]  mark = 2'h1;

  always #50 i_clk = ~i_clk;
  tlc_reader tlc_reader_i (.o_fclk(i_fclk), .o_gap(i_gap));
  tlc_coder #(.HALF_CYC(H)) tlc_coder_i (.i_clk, .i_nrst, .i_ce, .i_fclk, .i_gap,
    .i_cfg, .i_manch, .i_seq_start, .i_tx_valid, .i_tx_bit, .o_tx_ready, .o_mod_bit,
    .o_damp, .o_ext_mode, .o_wr_active, .o_wr_valid, .i_wr_ready, .o_wr_data,
    .o_rx_overflow, .i_ovf_clr);

  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic fail(input string m);
    err_count++;
    $display("MISMATCH %0t %s timed out", $time, m);
    stop_test;
  endtask

  task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  // Popped events are compared in arrival order; an extra one meets xx
  // Sampled mid-cycle: these are the values the next rising edge pops with
  always @(negedge i_clk) if (i_wr_ready && o_wr_valid === 1'b1) begin
    chk(o_wr_data, exq.size() ? exq.pop_front() : 2'bxx, "rx event");
  end

  // Returns at the edge where the offered bit is taken
  task automatic tx_take;
    int   n;
    logic rdy;
    n = 0;
    do begin
      @(negedge i_clk);
      rdy = o_tx_ready;
      @(posedge i_clk);
      if (++n > 200) fail("tx ready");
    end while (rdy !== 1'b1);
  endtask

  // opt = {extended, marker, inverse, manchester}
  task automatic tx(input logic [3:0] opt);
    logic [3:0]  d;
    logic [31:0] c;
    logic        b;
    d = 4'($urandom);
    c = $urandom;
    c[3:0] = opt[3] ? (c[4] ? KEY_EXT_A : KEY_EXT_B) : 4'h3;
    c[CFG_XMODE] = 1'b1;
    c[CFG_MARKER] = opt[2];
    c[CFG_INVERSE] = opt[1];
    @(posedge i_clk);
    i_cfg <= c;
    i_manch <= opt[0];
    i_tx_bit <= d[3];
    i_tx_valid <= 1'b1;
    i_seq_start <= 1'b1;
    @(posedge i_clk);
    i_seq_start <= 1'b0;
    if (opt[3] && opt[2]) begin
      repeat (H) @(posedge i_clk);
      #1 chk(o_mod_bit, mark[1], "marker a");
      repeat (2 * H) @(posedge i_clk);
      #1 chk(o_mod_bit, mark[0], "marker b");
      mark = ~mark;
    end
    for (int k = 3; k >= 0; k--) begin
      tx_take;
      b = d[k] ^ (opt[3] & opt[1]);
      i_tx_bit <= d[(k + 3) % 4];
      if (k == 0) i_tx_valid <= 1'b0;
      repeat (H - 1) @(posedge i_clk);
      #1 chk({o_mod_bit, o_damp}, {b, opt[0] ^ b}, "bit first half");
      repeat (H) @(posedge i_clk);
      #1 chk({o_mod_bit, o_damp}, {b, b}, "bit second half");
    end
    repeat (2 * H + 2) @(posedge i_clk);
    #1 chk(o_damp, 1'b0, "idle damp");
  endtask

  // Model: classify each interval, stop at the first bad one, trim to keep
  task automatic rx(input bit fast, input int iv[$], input int keep);
    bit ab;
    bit z;
    bit o;
    ab = 1'b0;
    foreach (iv[k]) if (!ab) begin
      z = fast ? iv[k] inside {[8:15]} : iv[k] inside {[16:31]};
      o = fast ? iv[k] inside {[24:31]} : iv[k] inside {[48:63]};
      if (z || o) exq.push_back({1'b0, o});
      else begin
        exq.push_back(2'h3);
        ab = 1'b1;
      end
    end
    if (!ab) exq.push_back(2'h2);
    while (exq.size() > keep) void'(exq.pop_back());
    @(posedge i_clk);
    i_cfg[CFG_FAST] <= fast;
    i_wr_ready <= (keep == 99);
    repeat (4) @(posedge i_clk);
    tlc_reader_i.send(iv);
    repeat (4) @(posedge i_clk);
    if (!ab) #1 chk(o_wr_active, 1'b1, "write mode");
    // Long enough for the timeout in either mode
    repeat (60) @(posedge i_clk);
    #1 chk(o_rx_overflow, keep < 99, "overflow");
    @(posedge i_clk);
    i_wr_ready <= 1'b1;
    for (int n = 0; exq.size() > 0; n++) begin
      if (n > 3000) fail("rx drain");
      @(posedge i_clk);
    end
    #1 chk(o_wr_active, 1'b0, "write mode left");
    @(posedge i_clk);
    i_ovf_clr <= 1'b1;
    @(posedge i_clk);
    i_ovf_clr <= 1'b0;
    @(posedge i_clk);
    #1 chk(o_rx_overflow, 1'b0, "overflow clear");
  endtask

  initial begin
    logic [31:0] c;
    int          q[$];
    logic [3:0]  opts[6] = '{4'hC, 4'hF, 4'hE, 4'h7, 4'hD, 4'h9};
    c = $urandom(34);
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    for (int k = 0; k < 32; k++) begin
      c = $urandom;
      c[3:0] = k[3:0];
      c[CFG_XMODE] = k[4];
      i_cfg <= c;
      @(posedge i_clk);
      #1 chk(o_ext_mode, (k[3:0] == 6 || k[3:0] == 9) && k[4], "extended");
    end
    foreach (opts[k]) tx(opts[k]);
    for (int k = 0; k < 6; k++) q.push_back($urandom % 2 ? 27 : 12);
    rx(1'b1, q, 99);
    q = {24, 56, 56, 24};
    rx(1'b0, q, 99);
    q = {12, 27, 20};
    rx(1'b1, q, 99);
    q = {24, 40};
    rx(1'b0, q, 99);
    q = {};
    for (int k = 0; k < 40; k++) q.push_back(12);
    // The FIFO holds its depth and one more waits in the pending slot
    rx(1'b1, q, FIFO_DEPTH + 1);
    stop_test;
  end
endmodule
